// ==== rtl/gbc_pkg.sv ====
// Shared constants and types for the general-purpose bus cycle sizing controller.
package gbc_pkg;
  // Internal clock period; one timing step is one clock period.
  localparam int CLK_PERIOD_NS = 40;
  // Nanoseconds per timing step, derived from the clock.
  localparam int STEP_NS = CLK_PERIOD_NS;
  localparam int SET_W = 4;
  localparam int CNT_W = 6;
  localparam int DATA_W = 16;
  localparam int BYTE_W = 8;
  // Width-extension pad that turns a setting into a counter value.
  localparam logic [CNT_W-SET_W-1:0] SET_PAD = 2'h0;
  // A setting of n lasts n plus this many steps.
  localparam logic [CNT_W-1:0] STEP_ONE = 6'h01;
  localparam logic [CNT_W-1:0] CNT_ZERO = 6'h00;
  localparam logic [SET_W-1:0] SET_ZERO = 4'h0;
  localparam logic [SET_W-1:0] SET_ONE = 4'h1;
  // CPU access sizes.
  localparam logic [1:0] SIZE_8 = 2'h0;
  localparam logic [1:0] SIZE_16 = 2'h1;
  localparam logic [1:0] SIZE_32 = 2'h2;
  localparam logic [DATA_W-1:0] DATA_ZERO = 16'h0000;
  localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;
  // Controller states.
  typedef enum logic [1:0] {ST_IDLE, ST_ACTIVE, ST_RECOVER} gbc_state_type;
endpackage

// ==== rtl/gbc_ctrl.sv ====
// Bus cycle controller: one external 8/16-bit cycle per CPU cycle with size reply.
module gbc_ctrl (
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  input wire logic cpu_req_in,
  input wire logic cpu_write_in,
  input wire logic cpu_mem_in,
  input wire logic [1:0] cpu_size_in,
  input wire logic [gbc_pkg::DATA_W-1:0] cpu_wdata_in,
  input wire logic select_width_config_in,
  input wire logic [gbc_pkg::SET_W-1:0] cs_offset_in,
  input wire logic [gbc_pkg::SET_W-1:0] cs_pulse_in,
  input wire logic [gbc_pkg::SET_W-1:0] cs_recovery_in,
  input wire logic [gbc_pkg::SET_W-1:0] cmd_offset_in,
  input wire logic [gbc_pkg::SET_W-1:0] cmd_pulse_in,
  input wire logic [gbc_pkg::SET_W-1:0] ale_offset_in,
  input wire logic [gbc_pkg::SET_W-1:0] ale_pulse_in,
  input wire logic wait_ready_in,
  input wire logic io_wide_request_in,
  input wire logic mem_wide_request_in,
  input wire logic [gbc_pkg::DATA_W-1:0] ext_data_lines_in,
  output logic cpu_done_out,
  output logic [gbc_pkg::DATA_W-1:0] cpu_rdata_out,
  output logic size8_reply_out,
  output logic size16_reply_out,
  output logic periph_select_out,
  output logic addr_latch_strobe_out,
  output logic io_read_strobe_out,
  output logic io_write_strobe_out,
  output logic mem_read_strobe_out,
  output logic mem_write_strobe_out,
  output logic [gbc_pkg::DATA_W-1:0] ext_data_lines_out,
  output logic ext_data_low_byte_oe_b_out,
  output logic ext_data_high_oe_b_out
);
  gbc_pkg::gbc_state_type st_q;
  logic [gbc_pkg::CNT_W-1:0] cnt_q;
  logic [gbc_pkg::SET_W-1:0] rec_q;
  logic wr_q, mem_q;
  logic [1:0] size_q;
  logic [gbc_pkg::DATA_W-1:0] wdata_q;
  logic rdy_s1_q, rdy_s2_q, iow_s1_q, iow_s2_q, mw_s1_q, mw_s2_q;
  logic [gbc_pkg::DATA_W-1:0] dat_s1_q, dat_s2_q;

  // Pins are asynchronous, so each passes two flip-flops before use.
  always_ff @(posedge core_clk_in) begin
    rdy_s1_q <= wait_ready_in;
    rdy_s2_q <= rdy_s1_q;
    iow_s1_q <= io_wide_request_in;
    iow_s2_q <= iow_s1_q;
    mw_s1_q <= mem_wide_request_in;
    mw_s2_q <= mw_s1_q;
    dat_s1_q <= ext_data_lines_in;
    dat_s2_q <= dat_s1_q;
  end

  // Window edges: a setting n lasts n+1 steps, so windows start at off+1 and end at off+pw+2.
  wire [gbc_pkg::CNT_W-1:0] cs_beg = {gbc_pkg::SET_PAD, cs_offset_in} + gbc_pkg::STEP_ONE;
  wire [gbc_pkg::CNT_W-1:0] cs_end = cs_beg + {gbc_pkg::SET_PAD, cs_pulse_in} + gbc_pkg::STEP_ONE;
  wire [gbc_pkg::CNT_W-1:0] cmd_beg = {gbc_pkg::SET_PAD, cmd_offset_in} + gbc_pkg::STEP_ONE;
  wire [gbc_pkg::CNT_W-1:0] cmd_end = cmd_beg + {gbc_pkg::SET_PAD, cmd_pulse_in} + gbc_pkg::STEP_ONE;
  wire [gbc_pkg::CNT_W-1:0] ale_beg = {gbc_pkg::SET_PAD, ale_offset_in} + gbc_pkg::STEP_ONE;
  wire [gbc_pkg::CNT_W-1:0] ale_end = ale_beg + {gbc_pkg::SET_PAD, ale_pulse_in} + gbc_pkg::STEP_ONE;
  wire [gbc_pkg::CNT_W-1:0] cyc_end_a = (cs_end > cmd_end) ? cs_end : cmd_end;
  wire [gbc_pkg::CNT_W-1:0] cyc_end = (ale_end > cyc_end_a) ? ale_end : cyc_end_a;
  wire [gbc_pkg::CNT_W-1:0] cnt_nx = cnt_q + gbc_pkg::STEP_ONE;

  // State decode and timeline qualifiers.
  wire idle_w = (st_q == gbc_pkg::ST_IDLE);
  wire act_w = (st_q == gbc_pkg::ST_ACTIVE);
  wire recov_w = (st_q == gbc_pkg::ST_RECOVER);
  wire accept_w = idle_w && cpu_req_in;
  wire cmd_last_w = act_w && (cnt_nx == cmd_end);
  wire stall_w = cmd_last_w && !rdy_s2_q;
  wire acc_end_w = act_w && (cnt_nx >= cyc_end) && !stall_w;
  wire rec_done_w = recov_w && (rec_q == cs_recovery_in) && rdy_s2_q;
  wire cs_on_w = act_w && (cnt_q >= cs_beg) && (cnt_q < cs_end);
  wire cmd_on_w = act_w && (cnt_q >= cmd_beg) && (cnt_q < cmd_end);
  wire ale_on_w = act_w && (cnt_q >= ale_beg) && (cnt_q < ale_end);

  // Peripheral width: the wide request only widens, never narrows, the configured width.
  wire wide_sel_w = mem_q ? mw_s2_q : iow_s2_q;
  wire eff16_w = select_width_config_in || wide_sel_w;
  wire use16_w = eff16_w && (size_q != gbc_pkg::SIZE_8);
  // The reply names the width used: 16-bit only for a wide peripheral on a non-byte access; the CPU core does the splitting.
  wire rep16_w = use16_w;
  wire rep8_w = !use16_w;
  wire [gbc_pkg::DATA_W-1:0] rd_w = use16_w ? dat_s2_q : {gbc_pkg::BYTE_ZERO,
    dat_s2_q[gbc_pkg::BYTE_W-1:0]};
  wire drv_w = act_w && wr_q;

  // Sequencer: recovery always follows, even when no select pin is wired out.
  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      st_q <= gbc_pkg::ST_IDLE;
      cnt_q <= gbc_pkg::CNT_ZERO;
      rec_q <= gbc_pkg::SET_ZERO;
    end else begin
      case (st_q)
        gbc_pkg::ST_IDLE: begin
          cnt_q <= gbc_pkg::CNT_ZERO;
          rec_q <= gbc_pkg::SET_ZERO;
          if (accept_w) st_q <= gbc_pkg::ST_ACTIVE;
        end
        gbc_pkg::ST_ACTIVE: begin
          if (acc_end_w) st_q <= gbc_pkg::ST_RECOVER;
          if (!stall_w) cnt_q <= cnt_nx;
        end
        gbc_pkg::ST_RECOVER: begin
          if (rec_done_w) st_q <= gbc_pkg::ST_IDLE;
          else if (rdy_s2_q && rec_q != cs_recovery_in) rec_q <= rec_q + gbc_pkg::SET_ONE;
        end
        default: st_q <= gbc_pkg::ST_IDLE;
      endcase
    end
  end

  // Request capture; held for the whole external cycle.
  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      wr_q <= 1'b0;
      mem_q <= 1'b0;
      size_q <= gbc_pkg::SIZE_8;
      wdata_q <= gbc_pkg::DATA_ZERO;
    end else begin
      if (accept_w) begin
        wr_q <= cpu_write_in;
        mem_q <= cpu_mem_in;
        size_q <= cpu_size_in;
        wdata_q <= cpu_wdata_in;
      end
    end
  end

  // Pin and CPU-side outputs, all registered so the pins never glitch.
  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      periph_select_out <= 1'b0;
      addr_latch_strobe_out <= 1'b0;
      io_read_strobe_out <= 1'b0;
      io_write_strobe_out <= 1'b0;
      mem_read_strobe_out <= 1'b0;
      mem_write_strobe_out <= 1'b0;
      ext_data_lines_out <= gbc_pkg::DATA_ZERO;
      ext_data_low_byte_oe_b_out <= 1'b1;
      ext_data_high_oe_b_out <= 1'b1;
      cpu_done_out <= 1'b0;
      cpu_rdata_out <= gbc_pkg::DATA_ZERO;
      size8_reply_out <= 1'b0;
      size16_reply_out <= 1'b0;
    end else begin
      periph_select_out <= cs_on_w;
      addr_latch_strobe_out <= ale_on_w;
      io_read_strobe_out <= cmd_on_w && !mem_q && !wr_q;
      io_write_strobe_out <= cmd_on_w && !mem_q && wr_q;
      mem_read_strobe_out <= cmd_on_w && mem_q && !wr_q;
      mem_write_strobe_out <= cmd_on_w && mem_q && wr_q;
      ext_data_lines_out <= wdata_q;
      ext_data_low_byte_oe_b_out <= !drv_w;
      ext_data_high_oe_b_out <= !(drv_w && use16_w);
      cpu_done_out <= acc_end_w;
      if (acc_end_w && !wr_q) cpu_rdata_out <= rd_w;
      size8_reply_out <= acc_end_w && rep8_w;
      size16_reply_out <= acc_end_w && rep16_w;
    end
  end

  // Helper for checking: counts address-latch high cycles and marks stretched cycles.
  logic [gbc_pkg::CNT_W-1:0] ale_cnt_q;
  logic stretched_q;
  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      ale_cnt_q <= gbc_pkg::CNT_ZERO;
      stretched_q <= 1'b0;
    end else begin
      ale_cnt_q <= addr_latch_strobe_out ? ale_cnt_q + gbc_pkg::STEP_ONE : gbc_pkg::CNT_ZERO;
      if (accept_w) stretched_q <= 1'b0;
      else if (stall_w) stretched_q <= 1'b1;
    end
  end

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_b_in);

  one_cycle_a: assert property (idle_w && cpu_req_in |=> act_w ##0 !cpu_done_out)
    else $error("Request not taken into a single external cycle.");
  no_reaccept_a: assert property (cpu_done_out |-> !act_w)
    else $error("Done seen while a cycle is still active.");
  narrow8_a: assert property (acc_end_w && !use16_w |=> size8_reply_out && !size16_reply_out)
    else $error("Narrow peripheral did not get the 8-bit reply.");
  wide32_a: assert property (acc_end_w && use16_w && size_q == gbc_pkg::SIZE_32
    |=> size16_reply_out && !size8_reply_out)
    else $error("32-bit access to wide peripheral lacks the 16-bit reply.");
  match8_a: assert property (acc_end_w && size_q == gbc_pkg::SIZE_8 |=> size8_reply_out)
    else $error("Byte access did not get the matching reply.");
  low_lane_a: assert property (!ext_data_low_byte_oe_b_out && size_q == gbc_pkg::SIZE_8
    |-> ext_data_high_oe_b_out)
    else $error("Byte access drove the high lanes.");
  mem_space_a: assert property (act_w && mem_q |=> !io_read_strobe_out && !io_write_strobe_out)
    else $error("I/O strobe asserted on a memory-space cycle.");
  stretch_a: assert property (stall_w |=> act_w && cnt_q == $past(cnt_q) && !cpu_done_out)
    else $error("Command not stretched while ready is low.");
  rec_hold_a: assert property (recov_w && !rdy_s2_q |=> recov_w && rec_q == $past(rec_q))
    else $error("Recovery advanced while ready is low.");
  override_a: assert property (acc_end_w && wide_sel_w && size_q != gbc_pkg::SIZE_8
    |=> size16_reply_out)
    else $error("Wide request did not override the narrow width.");
  ale_width_a: assert property ($fell(addr_latch_strobe_out) && !stretched_q
    |-> ale_cnt_q == {gbc_pkg::SET_PAD, ale_pulse_in} + gbc_pkg::STEP_ONE)
    else $error("Latch strobe width is not setting plus one.");

  byte_read_c: cover property (acc_end_w && !wr_q && size_q == gbc_pkg::SIZE_8);
  wide_write_c: cover property (acc_end_w && wr_q && use16_w && size_q == gbc_pkg::SIZE_32);
  stretch_c: cover property (stall_w ##1 stall_w);
  override_c: cover property (acc_end_w && wide_sel_w && !select_width_config_in);
endmodule // gbc_ctrl

// ==== tb/gbc_periph_model.sv ====
// Peripheral model on the external side of the bus cycle controller.
module gbc_periph_model (
  input wire logic clk_in,
  input wire logic sel_in,
  input wire logic rd_in,
  input wire logic wr_in,
  input wire logic mem_in,
  input wire logic wide_in,
  input wire logic [3:0] stall_in,
  input wire logic [15:0] word_in,
  output logic ready_out,
  output logic io_wide_out,
  output logic mem_wide_out,
  output logic [15:0] data_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] stall_q = 4'h0;
  logic cmd_q = 1'b0;
  logic flip;
  // Wait states start at each strobe edge, so ready drops in that same cycle.
  // The drop at the falling edge lands in the select recovery, which must then wait too.
  assign flip = (rd_in | wr_in) != cmd_q;
  always @(posedge clk_in) begin
    cmd_q <= rd_in | wr_in;
    stall_q <= flip ? stall_in : stall_q - {3'h0, stall_q != 4'h0};
  end
  assign ready_out = !(stall_q != 4'h0 || (flip && stall_in != 4'h0));
  // Wide pins follow the select of the space in use.
  assign io_wide_out = wide_in & sel_in & !mem_in;
  assign mem_wide_out = wide_in & sel_in & mem_in;
  // Released lines show the inverse so stale data cannot pass as valid.
  assign data_out = (sel_in | rd_in) ? word_in : ~word_in;
endmodule // gbc_periph_model

// ==== tb/tb_top.sv ====
// Self-checking bench for the bus cycle sizing controller.
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, rst_b = 1'b0, req = 1'b0, w = 1'b0, m = 1'b0, cfg = 1'b0, wide = 1'b0;
  logic [1:0] sz = 2'h0;
  logic [3:0] cs_pw = 4'h3, cs_rec = 4'h2, cmd_pw = 4'h3, stall = 4'h0, cmd_off = 4'h0;
  logic [3:0] ale_pw = 4'h0;
  logic [15:0] wd = 16'h3c5a, word = 16'ha5c3;
  logic done, s8, s16, sel, ale, ior, iow, mr, mw, oel, oeh, rdy, iwd, mwd;
  logic [15:0] rdata, dout, din;
  logic [1:0] rep;
  logic [15:0] rdv;
  logic [17:0] ws;
  int n_rd, n_wr, n_bad, n_sel, n_done, n_ale, t_ale, t_cmd, error_cnt = 0, tests_run = 0;
  always #20 clk = ~clk;
  gbc_ctrl i_gbc_ctrl (.core_clk_in(clk), .rst_b_in(rst_b), .cpu_req_in(req),
    .cpu_write_in(w), .cpu_mem_in(m), .cpu_size_in(sz), .cpu_wdata_in(wd),
    .select_width_config_in(cfg), .cs_offset_in(cmd_off), .cs_pulse_in(cs_pw),
    .cs_recovery_in(cs_rec), .cmd_offset_in(cmd_off), .cmd_pulse_in(cmd_pw),
    .ale_offset_in(4'h0), .ale_pulse_in(ale_pw), .wait_ready_in(rdy),
    .io_wide_request_in(iwd), .mem_wide_request_in(mwd), .ext_data_lines_in(din),
    .cpu_done_out(done), .cpu_rdata_out(rdata), .size8_reply_out(s8),
    .size16_reply_out(s16), .periph_select_out(sel), .addr_latch_strobe_out(ale),
    .io_read_strobe_out(ior), .io_write_strobe_out(iow), .mem_read_strobe_out(mr),
    .mem_write_strobe_out(mw), .ext_data_lines_out(dout),
    .ext_data_low_byte_oe_b_out(oel), .ext_data_high_oe_b_out(oeh));
  gbc_periph_model i_gbc_periph_model (.clk_in(clk), .sel_in(sel), .rd_in(ior | mr),
    .wr_in(iow | mw), .mem_in(m), .wide_in(wide), .stall_in(stall), .word_in(word),
    .ready_out(rdy), .io_wide_out(iwd), .mem_wide_out(mwd), .data_out(din));
  // Compares one value and counts the result.
  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One CPU cycle; the request is held for hold extra edges to probe refusal.
  task automatic xfer(input logic wi, input logic mi, input logic [1:0] si, input int hold);
    int i;
    int lim;
    lim = 100;
    n_rd = 0; n_wr = 0; n_bad = 0; n_sel = 0; n_done = 0;
    n_ale = 0;
    t_ale = -1;
    t_cmd = -1;
    @(posedge clk);
    #1 w = wi;
    m = mi;
    sz = si;
    req = 1'b1;
    for (i = 0; i < lim; i++) begin
      @(posedge clk);
      #1 if (i == hold) req = 1'b0;
      n_rd += m ? mr : ior;
      n_wr += m ? mw : iow;
      n_bad += m ? (ior | iow) : (mr | mw);
      n_sel += sel;
      n_ale += ale;
      // First high samples; their gap is the command offset, free of pipeline latency.
      if (ale && t_ale < 0) t_ale = i;
      if ((m ? (mr | mw) : (ior | iow)) && t_cmd < 0) t_cmd = i;
      if (iow | mw) ws = {oeh, oel, dout};
      if (done === 1'b1) begin
        n_done++;
        rep = {s16, s8};
        rdv = rdata;
        lim = i + 10;
      end
    end
  endtask
  // Size replies, lanes and strobe widths across request and device widths.
  task automatic t_sizes;
    logic [4:0] tab [7] = '{5'b00000, 5'b01000, 5'b10000, 5'b10101, 5'b01101,
      5'b10011, 5'b00100};
    for (int i = 0; i < 7; i++) begin
      cfg = tab[i][2];
      wide = tab[i][1];
      word = 16'ha5c3 ^ 16'(i * 16'h1111);
      xfer(1'b0, 1'b0, tab[i][4:3], 0);
      chk(rep, tab[i][0] ? 2'h2 : 2'h1);
      chk(rdv, tab[i][0] ? word : {8'h00, word[7:0]});
      chk({n_done[3:0], n_rd[3:0], n_sel[3:0], n_bad[3:0]}, 16'h1440);
      chk(n_ale[3:0], 4'h1);
    end
    wide = 1'b0;
    $display("sizes test done");
  endtask
  // Both spaces, both directions: only the right strobes; both lanes on 16-bit writes, the low lane alone on byte writes.
  task automatic t_space;
    for (int k = 0; k < 4; k++) begin
      cfg = 1'b1;
      xfer(k[0], k[1], 2'h1, 0);
      chk({n_done[3:0], n_rd[3:0], n_wr[3:0], n_bad[3:0]}, k[0] ? 16'h1040 : 16'h1400);
      if (k[0]) chk(ws, {2'h0, wd});
      cfg = 1'b0;
      xfer(1'b1, k[1], 2'h0, 0);
      chk(ws[17:16], 2'h2);
    end
    $display("space test done");
  endtask
  // Strobe widths follow setting plus one clock for several settings.
  task automatic t_timing;
    logic [3:0] pw [4] = '{4'h0, 4'h1, 4'h2, 4'h4};
    for (int i = 0; i < 4; i++) begin
      cmd_pw = pw[i];
      cs_pw = pw[i];
      cmd_off = pw[i];
      ale_pw = pw[i];
      xfer(1'b1, 1'b0, 2'h0, 0);
      chk({n_wr[3:0], n_sel[3:0]}, {2{pw[i] + 4'h1}});
      chk({n_ale[3:0], 4'(t_cmd - t_ale)}, {pw[i] + 4'h1, pw[i]});
    end
    cmd_off = 4'h0;
    ale_pw = 4'h0;
    $display("timing test done");
  endtask
  // Ready held low stretches the read strobe; a held request gives one cycle.
  task automatic t_stall;
    cmd_pw = 4'h6;
    cs_pw = 4'h6;
    cs_rec = 4'h6;
    stall = 4'h3;
    xfer(1'b0, 1'b0, 2'h0, 0);
    // Seven programmed steps, plus one while synced ready is low at the last step.
    chk(n_rd[3:0], 4'h8);
    chk(rdv, {8'h00, word[7:0]});
    stall = 4'h0;
    xfer(1'b1, 1'b0, 2'h0, 4);
    chk(n_done[3:0], 4'h1);
    cs_rec = 4'h2;
    $display("stall test done");
  endtask
  // A reset in mid-cycle returns every output to idle; the next request runs normally.
  task automatic t_reset;
    @(posedge clk);
    #1 w = 1'b1;
    m = 1'b0;
    sz = 2'h1;
    req = 1'b1;
    repeat (4) @(posedge clk);
    #1 req = 1'b0;
    rst_b = 1'b0;
    repeat (2) @(posedge clk);
    #1 chk({done, s8, s16, sel, ale, ior, iow, mr, mw, oel, oeh}, 11'h003);
    chk(rdata, 16'h0000);
    rst_b = 1'b1;
    xfer(1'b1, 1'b0, 2'h1, 0);
    chk({n_done[3:0], n_wr[3:0]}, 8'h17);
    chk(rep, 2'h1);
    $display("reset test done");
  endtask
  // Prints the counts and the verdict, then stops.
  task automatic results;
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    #1 rst_b = 1'b1;
    t_sizes;
    t_space;
    t_timing;
    t_stall;
    t_reset;
    results;
  end
  // The tests need well under 2000 clocks; a hang is cut at 5000.
  initial begin
    #200000;
    error_cnt++;
    results;
  end
endmodule // tb_top
